// [hdl/mpr_pkg.sv]
package mpr_pkg;

	// ----------------------------------------------------------------
	// register offsets within the relocatable 64-byte window
	// ----------------------------------------------------------------
	localparam logic [5:0] OFS_ASYNC_CTLB0   = 6'h02;
	localparam logic [5:0] OFS_ASYNC_CTLB1   = 6'h03;
	localparam logic [5:0] OFS_ASYNC_STAT0   = 6'h04;
	localparam logic [5:0] OFS_ASYNC_STAT1   = 6'h05;
	localparam logic [5:0] OFS_ASYNC_TX0     = 6'h06;
	localparam logic [5:0] OFS_ASYNC_TX1     = 6'h07;
	localparam logic [5:0] OFS_ASYNC_RX0     = 6'h08;
	localparam logic [5:0] OFS_ASYNC_RX1     = 6'h09;
	localparam logic [5:0] OFS_CSIO_CTL      = 6'h0a;
	localparam logic [5:0] OFS_CSIO_DATA     = 6'h0b;
	localparam logic [5:0] OFS_TMR0_LOW      = 6'h0c;
	localparam logic [5:0] OFS_TMR0_HIGH     = 6'h0d;
	localparam logic [5:0] OFS_TMR_CTL       = 6'h10;
	localparam logic [5:0] OFS_TMR1_LOW      = 6'h14;
	localparam logic [5:0] OFS_TMR1_HIGH     = 6'h15;
	localparam logic [5:0] OFS_RLD1_LOW      = 6'h16;
	localparam logic [5:0] OFS_RLD1_HIGH     = 6'h17;
	localparam logic [5:0] OFS_FREE_RUN      = 6'h18;
	localparam logic [5:0] OFS_DMA0_SRC_LOW  = 6'h20;
	localparam logic [5:0] OFS_DMA0_SRC_HIGH = 6'h21;
	localparam logic [5:0] OFS_DMA0_SRC_BANK = 6'h22;
	localparam logic [5:0] OFS_DMA0_DST_LOW  = 6'h23;
	localparam logic [5:0] OFS_DMA0_DST_HIGH = 6'h24;
	localparam logic [5:0] OFS_DMA0_DST_BANK = 6'h25;
	localparam logic [5:0] OFS_OP_MODE       = 6'h3e;
	localparam logic [5:0] OFS_IO_CTL        = 6'h3f;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTLB_SS_LSB   = 0;
	localparam int CTLB_DR_BIT   = 3;
	localparam int CTLB_PS_BIT   = 5;
	localparam int CTLB_CTS_BIT  = 7;
	localparam int STAT_TDRE_BIT = 1;
	localparam int STAT_DCD_BIT  = 2;
	localparam int STAT_RDRF_BIT = 7;
	localparam int OPERATING_MODE_CONTROL_FETCH_BIT  = 7;
	localparam int OPERATING_MODE_CONTROL_COMPAT_BIT = 5;
	localparam int IOCTL_BASE_LSB  = 6;
	localparam int BANK_BITS       = 3;
	localparam logic [1:0] BASE_FORBIDDEN = 2'h3;
	localparam logic [2:0] SS_EXTERNAL    = 3'h7;

	// ----------------------------------------------------------------
	// divide factors and tick counts
	// ----------------------------------------------------------------
	localparam int DIV_W = 17;
	localparam logic [DIV_W-1:0] ASYNC_PRE_LO  = 17'h0000a;
	localparam logic [DIV_W-1:0] ASYNC_PRE_HI  = 17'h0001e;
	localparam logic [DIV_W-1:0] ASYNC_MUL_LO  = 17'h00010;
	localparam logic [DIV_W-1:0] ASYNC_MUL_HI  = 17'h00040;
	localparam logic [DIV_W-1:0] CSIO_DIV_BASE = 17'h00014;
	localparam logic [4:0]       TMR_TICK_CNT  = 5'h14;
	localparam logic [4:0]       FRC_TICK_CNT  = 5'h0a;
	localparam logic [7:0]       OPERATING_MODE_CONTROL_RST      = 8'he0;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       io_request_strobe_n;
		logic       rd_n;
		logic       wr_n;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mpr_io_req_t;

	typedef struct packed {
		logic [1:0]      base;
		logic [7:0]      operating_mode_control;
		logic [1:0][7:0] ctlb;
		logic [1:0][7:0] tdr;
		logic [1:0][7:0] rdr;
		logic [1:0]      rdrf;
		logic [1:0]      tdre;
		logic [7:0]      csio_ctl;
		logic [7:0]      csio_tx;
		logic [7:0]      csio_rx;
		logic [7:0]      tmr_ctl;
		logic [15:0]     tmr0;
		logic [15:0]     tmr1;
		logic [15:0]     rld1;
		logic [1:0][7:0] hi_latch;
		logic [18:0]     sar;
		logic [18:0]     dar;
		logic [7:0]      free_running_counter;
		logic [4:0]      tmr_pre;
		logic [4:0]      frc_pre;
		logic            rd_seen;
		logic            wr_seen;
		logic [7:0]      rdata;
		logic            rdata_oe;
		logic [1:0]      tx_load;
		logic            csio_load;
		logic [1:0]      tmr_zero;
		logic            dma_req;
	} mpr_regs_t;

	localparam mpr_regs_t REGS_RST = '{operating_mode_control: OPERATING_MODE_CONTROL_RST, tdre: 2'h3, default: '0};

endpackage

// [hdl/mpr_baud_div.sv]
`timescale 1ns/1ps

module mpr_baud_div #(
	parameter int W = 17
) (
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	input  wire logic [W-1:0] divisor_in,
	input  wire logic         ext_sel_in,
	input  wire logic         ext_clk_in,
	output logic              tick_out
);

	logic [W-1:0] cnt_q;
	logic [W-1:0] cnt_d;
	logic [2:0]   ext_q;
	logic [2:0]   ext_d;
	logic         tick_d;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		// stage 0 is only ever read by stage 1
		ext_d  = {ext_q[1:0], ext_clk_in};
		tick_d = 1'b0;
		cnt_d  = cnt_q + 1'b1;
		if (ext_sel_in) begin
			cnt_d  = '0;
			tick_d = ext_q[1] & ~ext_q[2];
		end else if (cnt_q >= divisor_in - 1'b1) begin
			// >= so a shrinking divisor cannot run the count away
			cnt_d  = '0;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cnt_q    <= '0;
			ext_q    <= '0;
			tick_out <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			ext_q    <= ext_d;
			tick_out <= tick_d;
		end
	end

endmodule // mpr_baud_div

// [hdl/mpr_regmap.sv]
`timescale 1ns/1ps

module mpr_regmap (
	input  wire logic                 clk_in,
	input  wire logic                 reset_in,
	input  wire mpr_pkg::mpr_io_req_t io_req_in,
	output logic [7:0]                io_rdata_out,
	output logic                      io_rdata_oe_out,
	input  wire logic [1:0]           cts_n_in,
	input  wire logic                 carrier_detect_ch0_n_in,
	input  wire logic [1:0]           async_ext_clk_in,
	input  wire logic                 csio_ext_clk_in,
	input  wire logic [1:0][7:0]      async_rx_byte_in,
	input  wire logic [1:0]           async_rx_valid_in,
	input  wire logic [1:0]           async_tx_taken_in,
	input  wire logic [7:0]           csio_rx_byte_in,
	input  wire logic                 csio_rx_valid_in,
	input  wire logic                 dma0_external_request_n_in,
	input  wire logic                 dma0_src_is_io_in,
	output logic [1:0]                async_baud_tick_out,
	output logic                      csio_baud_tick_out,
	output logic [1:0][7:0]           async_tx_byte_out,
	output logic [1:0]                async_tx_load_out,
	output logic [7:0]                csio_tx_byte_out,
	output logic                      csio_tx_load_out,
	output logic                      fetch_cycle_strobe_enable_out,
	output logic                      io_timing_compat_out,
	output logic [1:0]                timer_zero_out,
	output logic [18:0]               dma0_source_addr_out,
	output logic [18:0]               dma0_dest_addr_out,
	output logic                      dma0_request_out
);

	localparam int DW = mpr_pkg::DIV_W;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [DW-1:0] async_divisor(input logic [7:0] ctlb);
		logic [DW-1:0] pre;
		logic [DW-1:0] mul;
		pre = ctlb[mpr_pkg::CTLB_PS_BIT] ? mpr_pkg::ASYNC_PRE_HI : mpr_pkg::ASYNC_PRE_LO;
		mul = ctlb[mpr_pkg::CTLB_DR_BIT] ? mpr_pkg::ASYNC_MUL_HI : mpr_pkg::ASYNC_MUL_LO;
		return DW'(pre * mul) << ctlb[mpr_pkg::CTLB_SS_LSB +: 3];
	endfunction

	function automatic logic is_ext(input logic [7:0] ctl);
		return ctl[mpr_pkg::CTLB_SS_LSB +: 3] == mpr_pkg::SS_EXTERNAL;
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] cts_s1_q;
	logic [1:0] cts_s2_q;
	logic       dcd_s1_q;
	logic       dcd_s2_q;
	logic       dreq_s1_q;
	logic       dreq_s2_q;

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			cts_s1_q  <= '1;
			cts_s2_q  <= '1;
			dcd_s1_q  <= 1'b1;
			dcd_s2_q  <= 1'b1;
			dreq_s1_q <= 1'b1;
			dreq_s2_q <= 1'b1;
		end else begin
			cts_s1_q  <= cts_n_in;
			cts_s2_q  <= cts_s1_q;
			dcd_s1_q  <= carrier_detect_ch0_n_in;
			dcd_s2_q  <= dcd_s1_q;
			dreq_s1_q <= dma0_external_request_n_in;
			dreq_s2_q <= dreq_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	mpr_pkg::mpr_regs_t q;
	mpr_pkg::mpr_regs_t d;
	logic               hit;
	logic               rd_now;
	logic               wr_now;
	logic [5:0]         ofs;
	logic [7:0]         wdat;

	// no decode at base 3: that window overlaps the system registers
	assign hit    = (io_req_in.addr[7:6] == q.base) && (q.base != mpr_pkg::BASE_FORBIDDEN);
	assign rd_now = hit && !io_req_in.io_request_strobe_n && !io_req_in.rd_n;
	assign wr_now = hit && !io_req_in.io_request_strobe_n && !io_req_in.wr_n;
	assign ofs    = io_req_in.addr[5:0];
	assign wdat   = io_req_in.wdata;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic       tmr_tick;
		logic       frc_tick;
		logic       rd_start;
		logic       wr_start;
		logic [1:0] req_sel;
		logic [7:0] rmux;
		logic       rvalid;
		rmux      = 8'h00;
		rvalid    = 1'b1;
		req_sel   = 2'h0;
		tmr_tick  = 1'b0;
		frc_tick  = 1'b0;
		d         = q;
		d.rd_seen = rd_now;
		d.wr_seen = wr_now;
		d.tx_load   = '0;
		d.csio_load = 1'b0;
		d.tmr_zero  = '0;
		rd_start  = rd_now && !q.rd_seen;
		wr_start  = wr_now && !q.wr_seen;

		// timer and free-running tick prescalers
		tmr_tick  = q.tmr_pre == mpr_pkg::TMR_TICK_CNT - 5'h01;
		frc_tick  = q.frc_pre == mpr_pkg::FRC_TICK_CNT - 5'h01;
		d.tmr_pre = tmr_tick ? 5'h00 : q.tmr_pre + 5'h01;
		d.frc_pre = frc_tick ? 5'h00 : q.frc_pre + 5'h01;
		if (frc_tick) begin
			d.free_running_counter = q.free_running_counter - 8'h01;
		end
		if (tmr_tick && q.tmr_ctl[0]) begin
			d.tmr0        = q.tmr0 - 16'h0001;
			d.tmr_zero[0] = q.tmr0 == 16'h0001;
		end
		if (tmr_tick && q.tmr_ctl[1]) begin
			d.tmr1        = (q.tmr1 == 16'h0000) ? q.rld1 : q.tmr1 - 16'h0001;
			d.tmr_zero[1] = q.tmr1 == 16'h0001;
		end

		// read mux; high bytes of the counts come from the latch
		unique case (ofs)
			mpr_pkg::OFS_ASYNC_CTLB0,
			mpr_pkg::OFS_ASYNC_CTLB1: begin
				rmux = q.ctlb[ofs[0]];
				rmux[mpr_pkg::CTLB_CTS_BIT] = cts_s2_q[ofs[0]];
			end
			mpr_pkg::OFS_ASYNC_STAT0,
			mpr_pkg::OFS_ASYNC_STAT1: begin
				rmux = 8'h00;
				rmux[mpr_pkg::STAT_RDRF_BIT] = q.rdrf[ofs[0]];
				rmux[mpr_pkg::STAT_TDRE_BIT] = q.tdre[ofs[0]];
				rmux[mpr_pkg::STAT_DCD_BIT]  = !ofs[0] && dcd_s2_q;
			end
			mpr_pkg::OFS_ASYNC_TX0,
			mpr_pkg::OFS_ASYNC_TX1:     rmux = q.tdr[ofs[0]];
			mpr_pkg::OFS_ASYNC_RX0,
			mpr_pkg::OFS_ASYNC_RX1:     rmux = q.rdr[ofs[0]];
			mpr_pkg::OFS_CSIO_CTL:      rmux = q.csio_ctl;
			mpr_pkg::OFS_CSIO_DATA:     rmux = q.csio_rx;
			mpr_pkg::OFS_TMR0_LOW:      rmux = q.tmr0[7:0];
			mpr_pkg::OFS_TMR0_HIGH:     rmux = q.hi_latch[0];
			mpr_pkg::OFS_TMR_CTL:       rmux = q.tmr_ctl;
			mpr_pkg::OFS_TMR1_LOW:      rmux = q.tmr1[7:0];
			mpr_pkg::OFS_TMR1_HIGH:     rmux = q.hi_latch[1];
			mpr_pkg::OFS_RLD1_LOW:      rmux = q.rld1[7:0];
			mpr_pkg::OFS_RLD1_HIGH:     rmux = q.rld1[15:8];
			mpr_pkg::OFS_FREE_RUN:      rmux = q.free_running_counter;
			mpr_pkg::OFS_DMA0_SRC_LOW:  rmux = q.sar[7:0];
			mpr_pkg::OFS_DMA0_SRC_HIGH: rmux = q.sar[15:8];
			mpr_pkg::OFS_DMA0_SRC_BANK: rmux = {5'h00, q.sar[18:16]};
			mpr_pkg::OFS_DMA0_DST_LOW:  rmux = q.dar[7:0];
			mpr_pkg::OFS_DMA0_DST_HIGH: rmux = q.dar[15:8];
			mpr_pkg::OFS_DMA0_DST_BANK: rmux = {5'h00, q.dar[18:16]};
			mpr_pkg::OFS_OP_MODE:       rmux = q.operating_mode_control;
			mpr_pkg::OFS_IO_CTL:        rmux = {q.base, 6'h00};
			default: begin
				// offsets owned by blocks outside this map: leave bus alone
				rmux   = 8'h00;
				rvalid = 1'b0;
			end
		endcase
		d.rdata    = rd_now ? rmux : 8'h00;
		d.rdata_oe = rd_now && rvalid;

		// read side effects on the first cycle of the strobe only
		if (rd_start) begin
			if (ofs == mpr_pkg::OFS_TMR0_LOW) begin
				d.hi_latch[0] = q.tmr0[15:8];
			end
			if (ofs == mpr_pkg::OFS_TMR1_LOW) begin
				d.hi_latch[1] = q.tmr1[15:8];
			end
			if (ofs == mpr_pkg::OFS_ASYNC_RX0 || ofs == mpr_pkg::OFS_ASYNC_RX1) begin
				d.rdrf[ofs[0]] = 1'b0;
			end
		end

		// writes win over counting in the same cycle
		if (wr_start) begin
			unique case (ofs)
				mpr_pkg::OFS_ASYNC_CTLB0,
				mpr_pkg::OFS_ASYNC_CTLB1: begin
					d.ctlb[ofs[0]] = wdat;
					d.ctlb[ofs[0]][mpr_pkg::CTLB_CTS_BIT] = 1'b0;
				end
				mpr_pkg::OFS_ASYNC_TX0,
				mpr_pkg::OFS_ASYNC_TX1: begin
					d.tdr[ofs[0]]     = wdat;
					d.tdre[ofs[0]]    = 1'b0;
					d.tx_load[ofs[0]] = 1'b1;
				end
				mpr_pkg::OFS_CSIO_CTL:      d.csio_ctl = wdat;
				mpr_pkg::OFS_CSIO_DATA: begin
					d.csio_tx   = wdat;
					d.csio_load = 1'b1;
				end
				mpr_pkg::OFS_TMR0_LOW:      d.tmr0[7:0]  = wdat;
				mpr_pkg::OFS_TMR0_HIGH:     d.tmr0[15:8] = wdat;
				mpr_pkg::OFS_TMR_CTL:       d.tmr_ctl    = wdat;
				mpr_pkg::OFS_TMR1_LOW:      d.tmr1[7:0]  = wdat;
				mpr_pkg::OFS_TMR1_HIGH:     d.tmr1[15:8] = wdat;
				mpr_pkg::OFS_RLD1_LOW:      d.rld1[7:0]  = wdat;
				mpr_pkg::OFS_RLD1_HIGH:     d.rld1[15:8] = wdat;
				mpr_pkg::OFS_DMA0_SRC_LOW:  d.sar[7:0]   = wdat;
				mpr_pkg::OFS_DMA0_SRC_HIGH: d.sar[15:8]  = wdat;
				mpr_pkg::OFS_DMA0_SRC_BANK: d.sar[18:16] = wdat[mpr_pkg::BANK_BITS-1:0];
				mpr_pkg::OFS_DMA0_DST_LOW:  d.dar[7:0]   = wdat;
				mpr_pkg::OFS_DMA0_DST_HIGH: d.dar[15:8]  = wdat;
				mpr_pkg::OFS_DMA0_DST_BANK: d.dar[18:16] = wdat[mpr_pkg::BANK_BITS-1:0];
				mpr_pkg::OFS_OP_MODE:       d.operating_mode_control       = wdat;
				mpr_pkg::OFS_IO_CTL:        d.base       = wdat[mpr_pkg::IOCTL_BASE_LSB +: 2];
				default: ;
			endcase
		end

		// hardware sets come last so they win over a clear
		for (int i = 0; i < 2; i++) begin
			if (async_rx_valid_in[i]) begin
				d.rdr[i]  = async_rx_byte_in[i];
				d.rdrf[i] = 1'b1;
			end
			if (async_tx_taken_in[i]) begin
				d.tdre[i] = 1'b1;
			end
		end
		if (csio_rx_valid_in) begin
			d.csio_rx = csio_rx_byte_in;
		end

		// the I/O-side bank picks the request source
		req_sel = dma0_src_is_io_in ? q.sar[17:16] : q.dar[17:16];
		unique case (req_sel)
			2'h0:    d.dma_req = !dreq_s2_q;
			2'h1:    d.dma_req = q.rdrf[0];
			2'h2:    d.dma_req = q.tdre[1];
			default: d.dma_req = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			q <= mpr_pkg::REGS_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// baud dividers
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_async
		mpr_baud_div #(
			.W(DW)
		) u_div (
			.clk_in    (clk_in),
			.reset_in  (reset_in),
			.divisor_in(async_divisor(q.ctlb[g])),
			.ext_sel_in(is_ext(q.ctlb[g])),
			.ext_clk_in(async_ext_clk_in[g]),
			.tick_out  (async_baud_tick_out[g])
		);
	end

	mpr_baud_div #(
		.W(DW)
	) u_csio_div (
		.clk_in    (clk_in),
		.reset_in  (reset_in),
		.divisor_in(mpr_pkg::CSIO_DIV_BASE << q.csio_ctl[mpr_pkg::CTLB_SS_LSB +: 3]),
		.ext_sel_in(is_ext(q.csio_ctl)),
		.ext_clk_in(csio_ext_clk_in),
		.tick_out  (csio_baud_tick_out)
	);

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign io_rdata_out                  = q.rdata;
	assign io_rdata_oe_out               = q.rdata_oe;
	assign async_tx_byte_out             = q.tdr;
	assign async_tx_load_out             = q.tx_load;
	assign csio_tx_byte_out              = q.csio_tx;
	assign csio_tx_load_out              = q.csio_load;
	assign fetch_cycle_strobe_enable_out = q.operating_mode_control[mpr_pkg::OPERATING_MODE_CONTROL_FETCH_BIT];
	assign io_timing_compat_out          = q.operating_mode_control[mpr_pkg::OPERATING_MODE_CONTROL_COMPAT_BIT];
	assign timer_zero_out                = q.tmr_zero;
	assign dma0_source_addr_out          = q.sar;
	assign dma0_dest_addr_out            = q.dar;
	assign dma0_request_out              = q.dma_req;

endmodule // mpr_regmap

// [tb/mpr_regmap_checker.sv]
`timescale 1ns/1ps

module mpr_regmap_checker (
	input  wire logic                 clk_in,
	input  wire logic                 reset_in,
	input  wire mpr_pkg::mpr_io_req_t io_req_in,
	input  wire logic                 io_rdata_oe_out,
	input  wire logic                 dma0_src_is_io_in,
	input  wire logic [1:0]           async_baud_tick_out,
	input  wire logic                 csio_baud_tick_out,
	input  wire logic [1:0][7:0]      async_tx_byte_out,
	input  wire logic [1:0]           async_tx_load_out,
	input  wire logic [7:0]           csio_tx_byte_out,
	input  wire logic                 csio_tx_load_out,
	input  wire logic                 io_timing_compat_out,
	input  wire logic [18:0]          dma0_source_addr_out,
	input  wire logic                 dma0_request_out
);
	// ----------------------------------------------------------------
	// last cycle's request, for cause-and-effect checks
	// ----------------------------------------------------------------
	mpr_pkg::mpr_io_req_t req_d;
	mpr_pkg::mpr_io_req_t req_q;
	logic                 wr_q;

	always_comb req_d = io_req_in;
	always_ff @(posedge clk_in) req_q <= req_d;
	assign wr_q = !req_q.io_request_strobe_n && !req_q.wr_n;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);

	a_oe_after_read: assert property (
		io_rdata_oe_out |-> !req_q.io_request_strobe_n && !req_q.rd_n)
		else $error("read data driven without a read strobe");
	a_tx0_load_cause: assert property (
		async_tx_load_out[0] |-> wr_q && req_q.addr[5:0] == mpr_pkg::OFS_ASYNC_TX0
			&& async_tx_byte_out[0] == req_q.wdata)
		else $error("async transmit load without matching write");
	a_csio_load_cause: assert property (
		csio_tx_load_out |-> wr_q && req_q.addr[5:0] == mpr_pkg::OFS_CSIO_DATA
			&& csio_tx_byte_out == req_q.wdata)
		else $error("clocked serial load without matching write");
	a_csio_tick_gap: assert property (
		csio_baud_tick_out |=> !csio_baud_tick_out [*8])
		else $error("clocked serial ticks too close");
	a_async_tick_gap: assert property (
		async_baud_tick_out[0] |=> !async_baud_tick_out[0] [*8])
		else $error("async ticks too close");
	a_mode_by_write: assert property (
		$changed(io_timing_compat_out) |-> wr_q
			&& req_q.addr[5:0] == mpr_pkg::OFS_OP_MODE
			&& io_timing_compat_out == req_q.wdata[5])
		else $error("timing compat bit moved without a mode write");
	a_src_by_write: assert property (
		$changed(dma0_source_addr_out) |-> wr_q && req_q.addr[5:0] inside {6'h20, 6'h21, 6'h22})
		else $error("dma source address moved without a write");
	a_unused_source: assert property (
		dma0_src_is_io_in && dma0_source_addr_out[17:16] == 2'h3 |=> !dma0_request_out)
		else $error("dma request raised by unused source code");
endmodule // mpr_regmap_checker

bind mpr_regmap mpr_regmap_checker u_chk (
	.clk_in               (clk_in),
	.reset_in             (reset_in),
	.io_req_in            (io_req_in),
	.io_rdata_oe_out      (io_rdata_oe_out),
	.dma0_src_is_io_in    (dma0_src_is_io_in),
	.async_baud_tick_out  (async_baud_tick_out),
	.csio_baud_tick_out   (csio_baud_tick_out),
	.async_tx_byte_out    (async_tx_byte_out),
	.async_tx_load_out    (async_tx_load_out),
	.csio_tx_byte_out     (csio_tx_byte_out),
	.csio_tx_load_out     (csio_tx_load_out),
	.io_timing_compat_out (io_timing_compat_out),
	.dma0_source_addr_out (dma0_source_addr_out),
	.dma0_request_out     (dma0_request_out)
);

// [tb/mpr_regmap_tb.sv]
`timescale 1ns/1ps

module mpr_regmap_tb;
	logic                 clk_in = 1'b0;
	logic                 reset_in = 1'b1;
	mpr_pkg::mpr_io_req_t req = 19'h70000;
	logic [1:0]           cts_n = 2'h3;
	logic                 dcd_n = 1'b1;
	logic                 ext = 1'b0;
	logic [1:0][7:0]      rx_byte = '0;
	logic [1:0]           rx_valid = 2'h0;
	logic [1:0]           tx_taken = 2'h0;
	logic [7:0]           cs_rx = 8'h00;
	logic                 cs_rx_v = 1'b0;
	logic                 dreq_n = 1'b1;
	logic                 src_io = 1'b1;
	logic [7:0]           rd_w, rdata, cs_tx;
	logic                 oe_w, oe, ctick, fetch, compat, dreq;
	logic [1:0]           atick, tzero;
	logic [1:0][7:0]      atx;
	logic [18:0]          src_a, dst_a;
	int                   n_errors = 0;
	int                   n_compared = 0;

	always #4 clk_in = ~clk_in;
	// external serial clock, 100 system cycles, edges just after rising clk
	initial begin
		#5;
		forever #400 ext = ~ext;
	end

	mpr_regmap u_dut (
		.clk_in(clk_in), .reset_in(reset_in), .io_req_in(req),
		.io_rdata_out(rd_w), .io_rdata_oe_out(oe_w), .cts_n_in(cts_n),
		.carrier_detect_ch0_n_in(dcd_n), .async_ext_clk_in({ext, ext}),
		.csio_ext_clk_in(ext), .async_rx_byte_in(rx_byte), .async_rx_valid_in(rx_valid),
		.async_tx_taken_in(tx_taken), .csio_rx_byte_in(cs_rx), .csio_rx_valid_in(cs_rx_v),
		.dma0_external_request_n_in(dreq_n), .dma0_src_is_io_in(src_io),
		.async_baud_tick_out(atick), .csio_baud_tick_out(ctick),
		.async_tx_byte_out(atx), .async_tx_load_out(), .csio_tx_byte_out(cs_tx),
		.csio_tx_load_out(), .fetch_cycle_strobe_enable_out(fetch),
		.io_timing_compat_out(compat), .timer_zero_out(tzero),
		.dma0_source_addr_out(src_a), .dma0_dest_addr_out(dst_a),
		.dma0_request_out(dreq)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in) #1;
	endtask

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
		req = {3'h2, a, d};
		cyc(1);
		req = {3'h7, a, d};
		cyc(1);
	endtask

	task automatic io_rd(input logic [7:0] a);
		req = {3'h1, a, 8'h00};
		cyc(1);
		rdata = rd_w;
		oe = oe_w;
		req = {3'h7, a, 8'h00};
		cyc(2);
	endtask

	// waits out one tick, then counts cycles to the next
	task automatic gap(input int which, output int n);
		int i;
		i = 0;
		while ((which == 2 ? atick[1] : which ? ctick : atick[0]) !== 1'b1 && i < 20000) begin
			cyc(1);
			i++;
		end
		n = 0;
		do begin
			cyc(1);
			n++;
		end while ((which == 2 ? atick[1] : which ? ctick : atick[0]) !== 1'b1 && n < 20000);
	endtask

	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_mode;
		io_rd(8'h3e);
		chk("mode_rst", rdata, 8'he0);
		io_rd(8'h02);
		chk("ctlb0_rst", rdata, 8'h80);
		io_rd(8'h04);
		chk("stat0_rst", rdata, 8'h06);
		io_rd(8'h01);
		chk("unmapped_oe", oe, 1'b0);
		io_wr(8'h3e, 8'h00);
		chk("fetch_en", fetch, 1'b0);
		chk("compat", compat, 1'b0);
		$display("reset and mode done");
	endtask

	task automatic t_reloc;
		io_wr(8'h3f, 8'h40);
		io_rd(8'h7e);
		chk("base1_rd", {oe, rdata}, 9'h100);
		io_rd(8'h3e);
		chk("old_window", oe, 1'b0);
		io_wr(8'h7f, 8'h80);
		io_rd(8'hbe);
		chk("base2_rd", {oe, rdata}, 9'h100);
		io_rd(8'h7e);
		chk("base1_gone", oe, 1'b0);
		io_wr(8'hbf, 8'h00);
		io_rd(8'h3e);
		chk("base0_back", oe, 1'b1);
		$display("relocation done");
	endtask

	task automatic t_pins_serial;
		cts_n = 2'h2;
		dcd_n = 1'b0;
		cyc(6);
		io_wr(8'h02, 8'hff);
		io_rd(8'h02);
		chk("cts_ro", rdata, 8'h7f);
		io_wr(8'h04, 8'hff);
		io_rd(8'h04);
		chk("dcd_low", rdata, 8'h02);
		io_wr(8'h0b, 8'ha5);
		chk("csio_tx", cs_tx, 8'ha5);
		io_wr(8'h06, 8'h5a);
		chk("async_tx0", atx[0], 8'h5a);
		cs_rx = 8'h3c;
		cs_rx_v = 1'b1;
		cyc(1);
		cs_rx_v = 1'b0;
		io_rd(8'h0b);
		chk("csio_rx", rdata, 8'h3c);
		$display("pins and serial data done");
	endtask

	task automatic t_timer;
		logic [7:0] lo;
		int         i;
		io_wr(8'h10, 8'h00);
		io_wr(8'h0c, 8'h34);
		io_wr(8'h0d, 8'h12);
		io_rd(8'h0c);
		chk("t0_lo", rdata, 8'h34);
		io_rd(8'h0d);
		chk("t0_hi", rdata, 8'h12);
		io_wr(8'h14, 8'h02);
		io_wr(8'h15, 8'h00);
		io_wr(8'h16, 8'h05);
		io_wr(8'h17, 8'hc3);
		io_rd(8'h16);
		chk("rld_lo", rdata, 8'h05);
		io_rd(8'h17);
		chk("rld_hi", rdata, 8'hc3);
		io_wr(8'h0c, 8'h00);
		io_wr(8'h0d, 8'h01);
		io_wr(8'h10, 8'h01);
		io_rd(8'h0c);
		lo = rdata;
		cyc(45);
		io_rd(8'h0d);
		chk("t0_pair", ({rdata, lo} === 16'h0100) || ({rdata, lo} === 16'h00ff), 1'b1);
		io_wr(8'h10, 8'h02);
		i = 0;
		while (tzero[1] !== 1'b1 && i < 100) begin
			cyc(1);
			i++;
		end
		chk("t1_zero", tzero[1], 1'b1);
		io_wr(8'h10, 8'h00);
		io_rd(8'h18);
		lo = rdata;
		cyc(97);
		io_rd(8'h18);
		chk("frc_step", 8'(lo - rdata), 8'h0a);
		$display("timers done");
	endtask

	task automatic t_dma;
		io_wr(8'h20, 8'h11);
		io_wr(8'h21, 8'h22);
		io_wr(8'h22, 8'hff);
		io_wr(8'h23, 8'h33);
		io_wr(8'h24, 8'h44);
		io_wr(8'h25, 8'hfe);
		io_rd(8'h22);
		chk("src_bank", rdata, 8'h07);
		io_rd(8'h25);
		chk("dst_bank", rdata, 8'h06);
		chk("src_addr", src_a, 19'h72211);
		chk("dst_addr", dst_a, 19'h64433);
		io_wr(8'h22, 8'h00);
		dreq_n = 1'b0;
		cyc(6);
		chk("req_pin", dreq, 1'b1);
		rx_byte[0] = 8'h99;
		rx_valid = 2'h1;
		io_wr(8'h22, 8'h01);
		rx_valid = 2'h0;
		chk("req_rx0", dreq, 1'b1);
		io_rd(8'h08);
		chk("rx0_data", rdata, 8'h99);
		chk("req_rx0_clr", dreq, 1'b0);
		io_wr(8'h22, 8'h02);
		cyc(2);
		chk("req_tx1", dreq, 1'b1);
		io_wr(8'h07, 8'h00);
		cyc(2);
		chk("req_tx1_clr", dreq, 1'b0);
		tx_taken = 2'h2;
		cyc(1);
		tx_taken = 2'h0;
		io_wr(8'h22, 8'h03);
		cyc(2);
		chk("req_unused", dreq, 1'b0);
		src_io = 1'b0;
		cyc(3);
		chk("req_dest", dreq, 1'b1);
		dreq_n = 1'b1;
		src_io = 1'b1;
		$display("dma done");
	endtask

	task automatic t_baud;
		logic [7:0] cfg [6] = '{8'h00, 8'h20, 8'h09, 8'h28, 8'h04, 8'h07};
		int         n;
		int         e;
		foreach (cfg[k]) begin
			// switch to the pin clock just after its edge, clear of the last tick
			if (cfg[k][2:0] == 3'h7) begin
				@(posedge ext);
				cyc(4);
			end
			io_wr(8'h02, cfg[k]);
			e = ((cfg[k][5] ? 30 : 10) * (cfg[k][3] ? 64 : 16)) << cfg[k][2:0];
			if (cfg[k][2:0] == 3'h7)
				e = 100;
			gap(1'b0, n);
			gap(1'b0, n);
			chk("async_div", n, e);
		end
		for (int c = 0; c < 8; c++) begin
			if (c == 7) begin
				@(posedge ext);
				cyc(4);
			end
			io_wr(8'h0a, 8'(c));
			gap(1'b1, n);
			gap(1'b1, n);
			chk("csio_div", n, (c == 7) ? 100 : (20 << c));
		end
		io_wr(8'h03, 8'h20);
		gap(2, n);
		gap(2, n);
		chk("async1_div", n, 480);
		$display("baud rates done");
	endtask

	initial begin
		repeat (20) @(posedge clk_in);
		#1 reset_in = 1'b0;
		t_reset_mode;
		t_reloc;
		t_pins_serial;
		t_timer;
		t_dma;
		t_baud;
		stop_test;
	end

	initial begin
		repeat (100000) @(posedge clk_in);
		n_errors++;
		stop_test;
	end
endmodule // mpr_regmap_tb
